/* adc_conversion_control.sv */
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "adc_conversion_control_consts.svh"

module adc_conversion_control #(
	parameter int SETTLE_CYCLES = 3
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Clock sources and trigger from outside
	input  wire logic        alt_clock_in,
	input  wire logic        async_clock_in,
	input  wire logic        hw_trigger_in,
	// Analog front end
	input  wire logic        comparator_above,
	output logic [11:0]      dac_code,
	output logic             sample_enable,
	output logic [4:0]       channel_select,
	output logic             low_power_sel,
	// Interrupt and pins
	output logic             conversion_complete_irq,
	output logic [15:0]      pin_io_disable
);

	initial begin
		if (SETTLE_CYCLES < 3 || SETTLE_CYCLES > 15) begin
			$error("SETTLE_CYCLES must lie in 3..15");
		end
	end

	localparam logic [3:0] SETTLE_LOAD = 4'(SETTLE_CYCLES - 1);

	// Highest result bit for a mode
	function automatic logic [3:0] top_bit(input logic [1:0] mode);
		case (mode)
			`MODE_12BIT: top_bit = 4'hb;
			`MODE_10BIT: top_bit = 4'h9;
			default:     top_bit = 4'h7;
		endcase
	endfunction

	// Last count of the clock divider; low power never runs undivided
	function automatic logic [2:0] div_last(input logic [1:0] sel, input logic lp);
		logic [1:0] s;
		s = (lp && sel == 2'h0) ? 2'h1 : sel;
		div_last = 3'((4'h1 << s) - 4'h1);
	endfunction

	adc_conversion_control_pkg::conv_state_type state_reg, state_next;
	logic [7:0]  cfg_reg, cfg_next;
	logic [2:0]  ctrl_two_reg, ctrl_two_next;
	logic [6:0]  ctrl_one_reg, ctrl_one_next;
	logic        complete_reg, complete_next;
	logic        lock_reg, lock_next;
	logic [11:0] result_reg, result_next;
	logic [11:0] compare_reg, compare_next;
	logic [15:0] pins_reg, pins_next;
	logic [11:0] sar_reg, sar_next;
	logic [3:0]  bit_reg, bit_next;
	logic [3:0]  settle_reg, settle_next;
	logic [4:0]  sample_reg, sample_next;
	logic [2:0]  div_reg, div_next;
	logic        half_reg, half_next;
	logic [3:0]  sync1_reg, sync1_next;
	logic [3:0]  sync2_reg, sync2_next;
	logic [2:0]  sync3_reg, sync3_next;
	logic        aw_have_reg, aw_have_next;
	logic [7:0]  aw_addr_reg, aw_addr_next;
	logic        w_have_reg, w_have_next;
	logic [7:0]  w_data_reg, w_data_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;

	logic        do_write;
	logic        do_read;
	logic        base_tick;
	logic        conversion_clock_tick;
	logic        start;
	logic        finish;
	logic        set_flag;
	logic        clear_flag;
	logic        cmp_true;
	logic [11:0] final_code;
	logic [11:0] diff;
	logic [7:0]  rd_byte;

	always_comb begin
		// Defaults hold every register but half_reg, which toggles each cycle, and the sync flops, which shift each cycle
		state_next    = state_reg;
		cfg_next      = cfg_reg;
		ctrl_two_next = ctrl_two_reg;
		ctrl_one_next = ctrl_one_reg;
		complete_next = complete_reg;
		lock_next     = lock_reg;
		result_next   = result_reg;
		compare_next  = compare_reg;
		pins_next     = pins_reg;
		sar_next      = sar_reg;
		bit_next      = bit_reg;
		settle_next   = settle_reg;
		sample_next   = sample_reg;
		div_next      = div_reg;
		half_next     = ~half_reg;
		aw_have_next  = aw_have_reg;
		aw_addr_next  = aw_addr_reg;
		w_have_next   = w_have_reg;
		w_data_next   = w_data_reg;
		bvalid_next   = bvalid_reg;
		bresp_next    = bresp_reg;
		rvalid_next   = rvalid_reg;
		rdata_next    = rdata_reg;
		rresp_next    = rresp_reg;
		start         = 1'b0;
		finish        = 1'b0;
		set_flag      = 1'b0;
		clear_flag    = 1'b0;
		rd_byte       = 8'h00;

		// Outside levels pass two flops; edges are taken after the second
		sync1_next = {comparator_above, hw_trigger_in, async_clock_in, alt_clock_in};
		sync2_next = sync1_reg;
		sync3_next = sync2_reg[2:0];

		// Input clock source and divider
		case (cfg_reg[`CFG_CLOCK_HI:`CFG_CLOCK_LO])
			`CLK_BUS:      base_tick = 1'b1;
			`CLK_BUS_HALF: base_tick = half_reg;
			`CLK_ALT:      base_tick = sync2_reg[0] & ~sync3_reg[0];
			default:       base_tick = sync2_reg[1] & ~sync3_reg[1];
		endcase
		conversion_clock_tick = 1'b0;
		if (base_tick) begin
			if (div_reg >= div_last(cfg_reg[`CFG_DIVIDE_HI:`CFG_DIVIDE_LO],
					cfg_reg[`CFG_LOW_POWER_BIT])) begin
				div_next  = 3'h0;
				conversion_clock_tick = 1'b1;
			end else begin
				div_next = div_reg + 3'h1;
			end
		end

		// Bus handshakes
		do_write = aw_have_reg && w_have_reg && !bvalid_reg;
		do_read  = s_axi_arvalid && !rvalid_reg;
		if (s_axi_awvalid && !aw_have_reg) begin
			aw_have_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_reg) begin
			w_have_next = 1'b1;
			w_data_next = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
		end
		if (s_axi_bready && bvalid_reg) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_rready && rvalid_reg) begin
			rvalid_next = 1'b0;
		end

		// Register writes
		if (do_write) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = `RESP_OKAY;
			case ({aw_addr_reg[7:2], 2'b00})
				`OFS_CONV_CONFIG:   cfg_next = w_data_reg;
				`OFS_CONV_CTRL_TWO: ctrl_two_next = w_data_reg[6:4];
				`OFS_CONV_CTRL_ONE: begin
					ctrl_one_next = w_data_reg[6:0];
					clear_flag    = 1'b1;
					// A new setting aborts a conversion under way, unless it finishes or, with no new start, leaves sampling in this cycle
					state_next    = adc_conversion_control_pkg::ST_IDLE;
					if (!ctrl_two_reg[2] && w_data_reg[4:0] != `CHAN_DISABLED) begin
						start = 1'b1;
					end
				end
				`OFS_COMPARE_HIGH:  compare_next[11:8] = w_data_reg[3:0];
				`OFS_COMPARE_LOW:   compare_next[7:0] = w_data_reg;
				`OFS_PIN_CTRL_ONE:  pins_next[7:0] = w_data_reg;
				`OFS_PIN_CTRL_TWO:  pins_next[15:8] = w_data_reg;
				`OFS_RESULT_HIGH, `OFS_RESULT_LOW: bresp_next = `RESP_OKAY;
				default:            bresp_next = `RESP_SLVERR;
			endcase
		end

		// Register reads
		if (do_read) begin
			rvalid_next = 1'b1;
			rresp_next  = `RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				`OFS_CONV_CONFIG:   rd_byte = cfg_reg;
				`OFS_CONV_CTRL_TWO: rd_byte = {state_reg != adc_conversion_control_pkg::ST_IDLE,
						ctrl_two_reg, 4'h0};
				`OFS_CONV_CTRL_ONE: rd_byte = {complete_reg, ctrl_one_reg};
				`OFS_RESULT_HIGH: begin
					rd_byte   = {4'h0, result_reg[11:8]};
					lock_next = 1'b1;
				end
				`OFS_RESULT_LOW: begin
					rd_byte    = result_reg[7:0];
					lock_next  = 1'b0;
					clear_flag = 1'b1;
				end
				`OFS_COMPARE_HIGH:  rd_byte = {4'h0, compare_reg[11:8]};
				`OFS_COMPARE_LOW:   rd_byte = compare_reg[7:0];
				`OFS_PIN_CTRL_ONE:  rd_byte = pins_reg[7:0];
				`OFS_PIN_CTRL_TWO:  rd_byte = pins_reg[15:8];
				default:            rresp_next = `RESP_SLVERR;
			endcase
			rdata_next = {24'h000000, rd_byte};
		end

		// Hardware trigger on a rising edge while idle
		if (ctrl_two_reg[2] && state_reg == adc_conversion_control_pkg::ST_IDLE
				&& ctrl_one_reg[4:0] != `CHAN_DISABLED
				&& sync2_reg[2] && !sync3_reg[2]) begin
			start = 1'b1;
		end

		// Successive approximation; comparator high means input at or above trial code
		final_code = sar_reg;
		if (!sync2_reg[3]) begin
			final_code[bit_reg] = 1'b0;
		end
		diff     = final_code - compare_reg;
		cmp_true = ctrl_two_reg[0] ? (final_code >= compare_reg) : (final_code < compare_reg);

		case (state_reg)
			adc_conversion_control_pkg::ST_IDLE: begin
				sample_next = 5'h00;
			end
			adc_conversion_control_pkg::ST_SAMPLE: begin
				if (conversion_clock_tick) begin
					if (sample_reg == 5'(cfg_reg[`CFG_LONG_SAMPLE_BIT] ?
							`SAMPLE_LONG_TICKS - 1 : `SAMPLE_SHORT_TICKS - 1)) begin
						state_next  = adc_conversion_control_pkg::ST_CONVERT;
						bit_next    = top_bit(cfg_reg[`CFG_MODE_HI:`CFG_MODE_LO]);
						sar_next    = 12'h000;
						sar_next[top_bit(cfg_reg[`CFG_MODE_HI:`CFG_MODE_LO])] = 1'b1;
						settle_next = SETTLE_LOAD;
					end else begin
						sample_next = sample_reg + 5'h01;
					end
				end
			end
			adc_conversion_control_pkg::ST_CONVERT: begin
				if (settle_reg != 4'h0) begin
					settle_next = settle_reg - 4'h1;
				end else if (conversion_clock_tick) begin
					// Comparator always high walks to all ones, always low to zero
					sar_next = final_code;
					if (bit_reg == 4'h0) begin
						finish = 1'b1;
					end else begin
						bit_next              = bit_reg - 4'h1;
						sar_next[bit_reg - 4'h1] = 1'b1;
						settle_next           = SETTLE_LOAD;
					end
				end
			end
			default: state_next = adc_conversion_control_pkg::ST_IDLE;
		endcase

		if (finish) begin
			// A locked result is kept; the finished conversion is dropped
			if (!lock_reg && (!ctrl_two_reg[1] || cmp_true)) begin
				result_next = ctrl_two_reg[1] ? diff : final_code;
				set_flag    = 1'b1;
			end
			state_next = adc_conversion_control_pkg::ST_IDLE;
			if (ctrl_one_reg[5]) begin
				start = 1'b1;
			end
		end

		if (start) begin
			// Channel pin control bits do not gate conversion
			state_next  = adc_conversion_control_pkg::ST_SAMPLE;
			sample_next = 5'h00;
		end

		// Setting wins over clearing
		if (clear_flag) begin
			complete_next = 1'b0;
		end
		if (set_flag) begin
			complete_next = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= adc_conversion_control_pkg::ST_IDLE;
			cfg_reg      <= `CONV_CONFIG_RESET;
			ctrl_two_reg <= 3'h0;
			ctrl_one_reg <= 7'(`CONV_CTRL_ONE_RESET);
			complete_reg <= 1'b0;
			lock_reg     <= 1'b0;
			result_reg   <= 12'h000;
			compare_reg  <= 12'h000;
			pins_reg     <= 16'h0000;
			sar_reg      <= 12'h000;
			bit_reg      <= 4'h0;
			settle_reg   <= 4'h0;
			sample_reg   <= 5'h00;
			div_reg      <= 3'h0;
			half_reg     <= 1'b0;
			sync1_reg    <= 4'h0;
			sync2_reg    <= 4'h0;
			sync3_reg    <= 3'h0;
			aw_have_reg  <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_have_reg   <= 1'b0;
			w_data_reg   <= 8'h00;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= 2'h0;
			rvalid_reg   <= 1'b0;
			rdata_reg    <= 32'h00000000;
			rresp_reg    <= 2'h0;
		end else begin
			state_reg    <= state_next;
			cfg_reg      <= cfg_next;
			ctrl_two_reg <= ctrl_two_next;
			ctrl_one_reg <= ctrl_one_next;
			complete_reg <= complete_next;
			lock_reg     <= lock_next;
			result_reg   <= result_next;
			compare_reg  <= compare_next;
			pins_reg     <= pins_next;
			sar_reg      <= sar_next;
			bit_reg      <= bit_next;
			settle_reg   <= settle_next;
			sample_reg   <= sample_next;
			div_reg      <= div_next;
			half_reg     <= half_next;
			sync1_reg    <= sync1_next;
			sync2_reg    <= sync2_next;
			sync3_reg    <= sync3_next;
			aw_have_reg  <= aw_have_next;
			aw_addr_reg  <= aw_addr_next;
			w_have_reg   <= w_have_next;
			w_data_reg   <= w_data_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			rvalid_reg   <= rvalid_next;
			rdata_reg    <= rdata_next;
			rresp_reg    <= rresp_next;
		end
	end

	assign s_axi_awready           = !aw_have_reg;
	assign s_axi_wready            = !w_have_reg;
	assign s_axi_bvalid            = bvalid_reg;
	assign s_axi_bresp             = bresp_reg;
	assign s_axi_arready           = !rvalid_reg;
	assign s_axi_rvalid            = rvalid_reg;
	assign s_axi_rdata             = rdata_reg;
	assign s_axi_rresp             = rresp_reg;
	assign dac_code                = sar_reg;
	assign sample_enable           = state_reg == adc_conversion_control_pkg::ST_SAMPLE;
	assign channel_select          = ctrl_one_reg[4:0];
	assign low_power_sel           = cfg_reg[`CFG_LOW_POWER_BIT];
	assign conversion_complete_irq = complete_reg & ctrl_one_reg[6];
	assign pin_io_disable          = pins_reg;

endmodule // adc_conversion_control

/* adc_conversion_control_asserts.sv */
`timescale 1ns/10ps
`include "adc_conversion_control_consts.svh"

module adc_conversion_control_asserts (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	// Converter side
	input wire logic        sample_enable,
	input wire logic [4:0]  channel_select,
	input wire logic        low_power_sel,
	input wire logic        conversion_complete_irq,
	input wire logic [15:0] pin_io_disable
);
	// Last accepted address and data, so outputs can be tied to the access that caused them
	logic [7:0] aw_q;
	logic [7:0] w_q;
	logic [7:0] ar_q;

	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready)
			aw_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
			w_q <= s_axi_wdata[7:0];
		if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_AW_BUSY: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address taken twice");
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_RSV_ZERO: assert property (s_axi_rvalid && ar_q == `OFS_CONV_CTRL_TWO |-> s_axi_rdata[3:2] == 2'h0)
		else $error("unimplemented bits read nonzero");
	AST_LOW_POWER: assert property ($rose(s_axi_bvalid) && aw_q == `OFS_CONV_CONFIG |=> low_power_sel == w_q[7])
		else $error("low power output does not follow config");
	AST_CHANNEL: assert property ($rose(s_axi_bvalid) && aw_q == `OFS_CONV_CTRL_ONE |=> channel_select == w_q[4:0])
		else $error("channel output does not follow control one");
	AST_PINS: assert property ($rose(s_axi_bvalid) && aw_q == `OFS_PIN_CTRL_ONE |=> pin_io_disable[7:0] == w_q)
		else $error("pin disable does not follow pin control");
	AST_IRQ_CLEAR: assert property ($fell(conversion_complete_irq) |-> ##[0:1] (s_axi_bvalid || s_axi_rvalid))
		else $error("interrupt dropped without a register access");
	// An abort by a control write may cut the window short, so writes suspend this check
	AST_SAMPLE_MIN: assert property (disable iff (!aresetn || s_axi_awvalid || s_axi_bvalid)
		$rose(sample_enable) |=> sample_enable[*3]) else $error("sample window too short");
endmodule // adc_conversion_control_asserts

bind adc_conversion_control adc_conversion_control_asserts u_asserts (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
	.s_axi_wdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sample_enable,
	.channel_select, .low_power_sel, .conversion_complete_irq, .pin_io_disable
);

/* adc_conversion_control_consts.svh */
`ifndef ADC_CONVERSION_CONTROL_CONSTS_SVH
`define ADC_CONVERSION_CONTROL_CONSTS_SVH

// Register byte offsets
`define OFS_CONV_CONFIG      8'h00
`define OFS_CONV_CTRL_TWO    8'h04
`define OFS_CONV_CTRL_ONE    8'h08
`define OFS_RESULT_HIGH      8'h0c
`define OFS_RESULT_LOW       8'h10
`define OFS_COMPARE_HIGH     8'h14
`define OFS_COMPARE_LOW      8'h18
`define OFS_PIN_CTRL_ONE     8'h1c
`define OFS_PIN_CTRL_TWO     8'h20

// Configuration fields
`define CFG_LOW_POWER_BIT    7
`define CFG_DIVIDE_HI        6
`define CFG_DIVIDE_LO        5
`define CFG_LONG_SAMPLE_BIT  4
`define CFG_MODE_HI          3
`define CFG_MODE_LO          2
`define CFG_CLOCK_HI         1
`define CFG_CLOCK_LO         0

// Second control fields
`define CT2_ACTIVE_BIT       7
`define CT2_TRIGGER_BIT      6
`define CT2_CMP_EN_BIT       5
`define CT2_CMP_GT_BIT       4

// First control fields
`define CT1_COMPLETE_BIT     7
`define CT1_IRQ_EN_BIT       6
`define CT1_CONT_BIT         5
`define CT1_CHAN_HI          4
`define CT1_CHAN_LO          0

// Encodings
`define MODE_8BIT            2'h0
`define MODE_12BIT           2'h1
`define MODE_10BIT           2'h2
`define CLK_BUS              2'h0
`define CLK_BUS_HALF         2'h1
`define CLK_ALT              2'h2
`define CLK_ASYNC            2'h3
`define CHAN_DISABLED        5'h1f

// Reset values
`define CONV_CONFIG_RESET    8'h00
`define CONV_CTRL_TWO_RESET  8'h00
`define CONV_CTRL_ONE_RESET  8'h1f

// Sample window in half conversion clock periods, and in whole periods rounded up
`define SAMPLE_SHORT_HALVES  7
`define SAMPLE_LONG_HALVES   47
`define SAMPLE_SHORT_TICKS   ((`SAMPLE_SHORT_HALVES + 1) / 2)
`define SAMPLE_LONG_TICKS    ((`SAMPLE_LONG_HALVES + 1) / 2)

// Bus response codes
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

/* adc_conversion_control_pkg.sv */
package adc_conversion_control_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT
	} conv_state_type;

endpackage

/* adc_conversion_control_tb_top.sv */
`timescale 1ns/10ps
`include "adc_conversion_control_consts.svh"

module adc_conversion_control_tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        alt_clock_in = 1'b0;
	logic        async_clock_in = 1'b0;
	logic        hw_trigger_in = 1'b0;
	logic        comparator_above = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        sample_enable, low_power_sel, conversion_complete_irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, wresp, rresp;
	logic [31:0] s_axi_rdata, rdat;
	logic [11:0] dac_code;
	logic [4:0]  channel_select;
	logic [15:0] pin_io_disable;
	logic [3:0]  cnt = 4'h0;
	logic        full = 1'b1;
	int          n_errors = 0;
	int          tests_run = 0;
	int          scnt = 0;
	int          slen = 0;

	// One more settle cycle covers the bench's registered comparator
	adc_conversion_control #(
		.SETTLE_CYCLES(4)
	) dut (
		.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.alt_clock_in, .async_clock_in, .hw_trigger_in, .comparator_above, .dac_code, .sample_enable,
		.channel_select, .low_power_sel, .conversion_complete_irq, .pin_io_disable
	);

	always #20 aclk = ~aclk;

	// Input is either at full scale or at ground; window length is measured in bus cycles
	always @(posedge aclk) begin
		cnt <= cnt + 4'h1;
		alt_clock_in <= cnt[1];
		async_clock_in <= cnt[2];
		comparator_above <= full ? 1'b1 : (dac_code == 12'h000);
		if (sample_enable)
			scnt <= scnt + 1;
		else if (scnt != 0) begin
			slen <= scnt;
			scnt <= 0;
		end
	end

	task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, d};
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		wresp = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rdat = s_axi_rdata;
		rresp = s_axi_rresp;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(nm, rdat, {24'h000000, exp});
	endtask

	task automatic poll(input logic [7:0] a, input int b, input logic v);
		for (int i = 0; i < 200; i++) begin
			rd(a);
			if (rdat[b] === v)
				break;
		end
		chk("poll", rdat[b], v);
	endtask

	task automatic t_reset;
		rchk("config", `OFS_CONV_CONFIG, `CONV_CONFIG_RESET);
		rchk("ctrl two", `OFS_CONV_CTRL_TWO, `CONV_CTRL_TWO_RESET);
		rchk("ctrl one", `OFS_CONV_CTRL_ONE, `CONV_CTRL_ONE_RESET);
		chk("channel", channel_select, `CHAN_DISABLED);
		rd(8'h24);
		chk("unmapped read", {rresp, rdat}, {`RESP_SLVERR, 32'h0});
		wr(8'h24, 8'h55);
		chk("unmapped write", wresp, `RESP_SLVERR);
		$display("reset test done");
	endtask

	task automatic t_init;
		wr(`OFS_CONV_CONFIG, 8'h98);
		wr(`OFS_CONV_CTRL_TWO, 8'h00);
		wr(`OFS_CONV_CTRL_ONE, 8'h41);
		chk("low power", low_power_sel, 1'b1);
		chk("channel", channel_select, 5'h01);
		rchk("busy", `OFS_CONV_CTRL_TWO, 8'h80);
		poll(`OFS_CONV_CTRL_ONE, 7, 1'b1);
		chk("complete", rdat[7:0], 8'hc1);
		chk("irq", conversion_complete_irq, 1'b1);
		chk("dac", dac_code, 12'h3ff);
		chk("long window", slen >= 47 && slen <= 50, 1'b1);
		rchk("idle", `OFS_CONV_CTRL_TWO, 8'h00);
		rchk("high", `OFS_RESULT_HIGH, 8'h03);
		rchk("low", `OFS_RESULT_LOW, 8'hff);
		rchk("flag cleared", `OFS_CONV_CTRL_ONE, 8'h41);
		chk("irq cleared", conversion_complete_irq, 1'b0);
		$display("init test done");
	endtask

	task automatic t_modes;
		logic [7:0]  cfg [9] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h01, 8'h02, 8'h03, 8'h10, 8'h04};
		logic [11:0] res [9] = '{12'h0ff, 12'hfff, 12'h3ff, 12'h0ff, 12'h0ff, 12'h0ff, 12'h0ff, 12'h0ff, 12'h000};
		int          per [9] = '{1, 1, 1, 2, 2, 4, 8, 1, 1};
		int          tk;
		logic [3:0]  hi;
		for (int i = 0; i < 9; i++) begin
			full <= (i != 8);
			tk = cfg[i][4] ? 24 : 4;
			wr(`OFS_CONV_CONFIG, cfg[i]);
			wr(`OFS_CONV_CTRL_ONE, 8'h01);
			poll(`OFS_CONV_CTRL_ONE, 7, 1'b1);
			chk("done", rdat[7], 1'b1);
			rd(`OFS_RESULT_HIGH);
			hi = rdat[3:0];
			rd(`OFS_RESULT_LOW);
			chk("result", {hi, rdat[7:0]}, res[i]);
			chk("window", slen > (tk - 1) * per[i] && slen <= (tk + 1) * per[i], 1'b1);
		end
		full <= 1'b1;
		$display("mode test done");
	endtask

	task automatic t_cmp;
		wr(`OFS_CONV_CONFIG, 8'h08);
		wr(`OFS_COMPARE_HIGH, 8'h01);
		wr(`OFS_COMPARE_LOW, 8'h00);
		rchk("cmp high", `OFS_COMPARE_HIGH, 8'h01);
		rchk("cmp low", `OFS_COMPARE_LOW, 8'h00);
		wr(`OFS_CONV_CTRL_TWO, 8'h3c);
		rchk("ctrl two", `OFS_CONV_CTRL_TWO, 8'h30);
		wr(`OFS_CONV_CTRL_ONE, 8'h01);
		poll(`OFS_CONV_CTRL_ONE, 7, 1'b1);
		chk("above", rdat[7], 1'b1);
		rchk("diff high", `OFS_RESULT_HIGH, 8'h02);
		rchk("diff low", `OFS_RESULT_LOW, 8'hff);
		wr(`OFS_CONV_CTRL_TWO, 8'h20);
		wr(`OFS_CONV_CTRL_ONE, 8'h01);
		poll(`OFS_CONV_CTRL_TWO, 7, 1'b0);
		rchk("below", `OFS_CONV_CTRL_ONE, 8'h01);
		rchk("kept high", `OFS_RESULT_HIGH, 8'h02);
		rchk("kept low", `OFS_RESULT_LOW, 8'hff);
		$display("compare test done");
	endtask

	task automatic t_trig;
		wr(`OFS_CONV_CTRL_TWO, 8'h40);
		wr(`OFS_CONV_CONFIG, 8'h00);
		wr(`OFS_CONV_CTRL_ONE, 8'h01);
		rchk("no start", `OFS_CONV_CTRL_TWO, 8'h40);
		@(posedge aclk);
		hw_trigger_in <= 1'b1;
		repeat (4) @(posedge aclk);
		hw_trigger_in <= 1'b0;
		poll(`OFS_CONV_CTRL_ONE, 7, 1'b1);
		chk("hw done", rdat[7], 1'b1);
		wr(`OFS_CONV_CTRL_TWO, 8'h00);
		wr(`OFS_CONV_CTRL_ONE, 8'h21);
		poll(`OFS_CONV_CTRL_ONE, 7, 1'b1);
		chk("irq off", conversion_complete_irq, 1'b0);
		rchk("locked high", `OFS_RESULT_HIGH, 8'h00);
		full <= 1'b0;
		// Several conversions finish while the result is held
		repeat (300) @(posedge aclk);
		rchk("locked low", `OFS_RESULT_LOW, 8'hff);
		poll(`OFS_CONV_CTRL_ONE, 7, 1'b1);
		chk("next", rdat[7], 1'b1);
		rchk("new high", `OFS_RESULT_HIGH, 8'h00);
		rchk("new low", `OFS_RESULT_LOW, 8'h00);
		wr(`OFS_CONV_CTRL_ONE, 8'h1f);
		$display("trigger test done");
	endtask

	task automatic t_pins;
		wr(`OFS_PIN_CTRL_ONE, 8'h02);
		wr(`OFS_PIN_CTRL_TWO, 8'h80);
		chk("pins", pin_io_disable, 16'h8002);
		rchk("pin two", `OFS_PIN_CTRL_TWO, 8'h80);
		$display("pin test done");
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_init();
		t_modes();
		t_cmp();
		t_trig();
		t_pins();
		wrap_up();
	end

	initial begin
		repeat (60000) @(posedge aclk);
		n_errors++;
		wrap_up();
	end
endmodule // adc_conversion_control_tb_top
